// ### design/otpps_addr_map.sv
// Purpose: maps array addresses to image source addresses and picks the range
// Assumes: image kind is steady while a job runs
// Notes: purely combinational
`include "otpps_defines.svh"
module otpps_addr_map
    import otpps_pkg::*;
#(
    parameter logic [14:0] HALF_ADDR = `OTPPS_ADDR_HALF
) (
    input  wire otpps_img_t  imgKind,
    input  wire logic [14:0] arrAddr,
    output logic [15:0]      srcAddr,
    output logic [14:0]      firstAddr,
    output logic             fillOnly
);
    wire logic lowHalf;

    assign lowHalf   = (arrAddr < HALF_ADDR);
    // 32KB image: 8000-FFFF lands at 0000-7FFF
    // 16KB image: C000-FFFF lands at 4000-7FFF
    assign srcAddr   = (imgKind == OTPPS_IMG_FULL)
                     ? (`OTPPS_SRC_BASE32 | {1'b0, arrAddr})                     // R08
                     : (`OTPPS_SRC_BASE16 | {2'b00, arrAddr[13:0]});             // R09
    assign firstAddr = (imgKind == OTPPS_IMG_HALF) ? HALF_ADDR                    // R09
                                                   : `OTPPS_ADDR_FIRST;          // R07
    assign fillOnly  = (imgKind == OTPPS_IMG_FILL) && lowHalf;                   // R10
endmodule

// ### design/otpps_sequencer.sv
// Purpose: programmer that writes and verifies the one-time array over its pins
// Assumes: image bytes are valid in the same cycle that imgRdAddr is driven with imgRdReq
// Notes: only program and read cycles are ever generated; no identification read
`include "otpps_defines.svh"
module otpps_sequencer
    import otpps_pkg::*;
#(
    parameter int PULSE1_CYC = (`OTPPS_PULSE1_US * `OTPPS_CLK_MHZ),
    parameter int PULSE2_CYC = (`OTPPS_PULSE2_US * `OTPPS_CLK_MHZ),
    parameter int TW         = 24,
    parameter logic [14:0] HALF_ADDR = `OTPPS_ADDR_HALF,
    parameter logic [14:0] LAST_ADDR = `OTPPS_ADDR_LAST
) (
    input  wire logic        core_clk,
    input  wire logic        nrst,
    input  wire logic        start,
    input  wire logic        modeTwo,
    input  wire otpps_img_t  imgKind,
    output logic             imgRdReq,
    output logic [15:0]      imgRdAddr,
    input  wire logic [7:0]  imgRdData,
    output logic [14:0]      array_address_lines,
    output logic [7:0]       array_data_lines_out,
    output logic             array_data_lines_oe_n,
    input  wire logic [7:0]  array_data_lines_in,
    output logic             chipEnable_n,
    output logic             outputEnable_n,
    output logic             busy,
    output logic             done,
    output logic             fail,
    output logic [14:0]      failAddr
);
    otpps_state_t state;
    otpps_state_t next_state;
    logic [14:0]  addr;
    logic [7:0]   wdata;
    logic [4:0]   pulses;
    logic         tLoad;
    logic [TW-1:0] tVal;
    logic         tDone;
    logic [15:0]  srcAddr;
    logic [14:0]  firstAddr;
    logic         fillOnly;
    logic         fetchPend;

    otpps_addr_map #(.HALF_ADDR(HALF_ADDR)) u_map (
        .imgKind   (imgKind),
        .arrAddr   (addr),
        .srcAddr   (srcAddr),
        .firstAddr (firstAddr),
        .fillOnly  (fillOnly)
    );

    otpps_timer #(.W(TW)) u_tmr (
        .core_clk (core_clk),
        .nrst     (nrst),
        .load     (tLoad),
        .loadVal  (tVal),
        .done     (tDone)
    );

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    wire logic [TW-1:0] pulseLen;
    wire logic [TW-1:0] overLen;
    wire logic          match;
    wire logic          lastAddr;
    wire logic          tooMany;

    assign pulseLen = modeTwo ? TW'(PULSE2_CYC) : TW'(PULSE1_CYC);               // R01 R04
    assign overLen  = TW'(`OTPPS_OVER_FACTOR * PULSE1_CYC) * TW'(pulses);         // R03
    assign match    = (array_data_lines_in == wdata);
    assign lastAddr = (addr == LAST_ADDR);                                        // R07
    assign tooMany  = (pulses >= 5'(`OTPPS_MAX_PULSES));                          // R02 R05

    // ----------------------------------------------------------------
    // state machine
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        tLoad      = 1'b0;
        tVal       = '0;
        unique case (state)
            OTPPS_IDLE: begin
                if (start) begin
                    next_state = OTPPS_FETCH;
                end
            end
            OTPPS_FETCH: begin
                if (!fetchPend) begin
                    next_state = OTPPS_SETUP;
                    tLoad      = 1'b1;
                    tVal       = TW'(`OTPPS_SETUP_CYC);
                end
            end
            OTPPS_SETUP: begin
                if (tDone) begin
                    next_state = OTPPS_PULSE;
                    tLoad      = 1'b1;
                    tVal       = pulseLen - TW'(1);                               // R01 R04
                end
            end
            OTPPS_PULSE: begin
                if (tDone) begin
                    next_state = OTPPS_RDSET;
                    tLoad      = 1'b1;
                    tVal       = TW'(`OTPPS_SETTLE_CYC);
                end
            end
            OTPPS_RDSET: begin
                if (tDone) begin
                    next_state = OTPPS_CHECK;
                end
            end
            OTPPS_CHECK: begin
                if (match && !modeTwo) begin
                    next_state = OTPPS_OVER;                                      // R03
                    tLoad      = 1'b1;
                    tVal       = overLen - TW'(1);
                end else if (match) begin
                    next_state = OTPPS_NEXT;                                      // R05
                end else if (tooMany) begin
                    next_state = OTPPS_DONE;
                end else begin
                    next_state = OTPPS_SETUP;                                     // R02 R05
                    tLoad      = 1'b1;
                    tVal       = TW'(`OTPPS_SETUP_CYC);
                end
            end
            OTPPS_OVER: begin
                if (tDone) begin
                    next_state = OTPPS_NEXT;
                end
            end
            OTPPS_NEXT: begin
                next_state = lastAddr ? OTPPS_VFETCH : OTPPS_FETCH;               // R06
            end
            OTPPS_VFETCH: begin
                if (!fetchPend) begin
                    next_state = OTPPS_VSET;
                    tLoad      = 1'b1;
                    tVal       = TW'(`OTPPS_SETTLE_CYC);
                end
            end
            OTPPS_VSET: begin
                if (tDone) begin
                    next_state = OTPPS_VCHECK;
                end
            end
            OTPPS_VCHECK: begin
                if (!match || lastAddr) begin
                    next_state = OTPPS_DONE;
                end else begin
                    next_state = OTPPS_VFETCH;
                end
            end
            OTPPS_DONE: begin
                if (start) begin
                    next_state = OTPPS_FETCH;
                end
            end
            default: begin
                next_state = OTPPS_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            state <= OTPPS_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // ----------------------------------------------------------------
    // address, data and pulse count
    // ----------------------------------------------------------------
    wire logic startJob;
    wire logic fetchNow;

    assign startJob = (state == OTPPS_IDLE || state == OTPPS_DONE) && start;
    assign fetchNow = (state == OTPPS_FETCH || state == OTPPS_VFETCH) && fetchPend;
    assign imgRdReq = fetchNow && !fillOnly;
    assign imgRdAddr = srcAddr;

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            addr <= `OTPPS_ADDR_FIRST;
        end else if (startJob) begin
            addr <= firstAddr;                                                    // R09
        end else if (state == OTPPS_NEXT) begin
            addr <= lastAddr ? firstAddr : addr + 15'h0001;                       // R06
        end else if (state == OTPPS_VCHECK && match && !lastAddr) begin
            addr <= addr + 15'h0001;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            fetchPend <= 1'b0;
        end else if (startJob || state == OTPPS_NEXT) begin
            fetchPend <= 1'b1;
        end else if (state == OTPPS_VCHECK && match && !lastAddr) begin
            fetchPend <= 1'b1;
        end else if (fetchNow) begin
            fetchPend <= 1'b0;
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            wdata <= 8'h00;
        end else if (fetchNow) begin
            wdata <= fillOnly ? `OTPPS_FILL_BYTE : imgRdData;                     // R10
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            pulses <= 5'h00;
        end else if (state == OTPPS_FETCH) begin
            pulses <= 5'h00;
        end else if (state == OTPPS_PULSE && tDone) begin
            pulses <= pulses + 5'h01;                                             // R02 R05
        end
    end

    // ----------------------------------------------------------------
    // pins and status
    // ----------------------------------------------------------------
    wire logic readPhase;
    wire logic driveData;

    assign readPhase = (state == OTPPS_RDSET || state == OTPPS_CHECK ||
                        state == OTPPS_VSET  || state == OTPPS_VCHECK);
    assign driveData = (next_state == OTPPS_SETUP || next_state == OTPPS_PULSE ||
                        next_state == OTPPS_OVER);

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            array_address_lines   <= 15'h0000;
            array_data_lines_out  <= 8'h00;
            array_data_lines_oe_n <= 1'b1;
            chipEnable_n          <= 1'b1;
            outputEnable_n        <= 1'b1;
        end else begin
            array_address_lines   <= addr;                                        // R12 R11
            array_data_lines_out  <= wdata;                                       // R01 R04
            array_data_lines_oe_n <= !driveData;                                  // R01 R03
            chipEnable_n          <= !((next_state == OTPPS_PULSE) ||
                                       (next_state == OTPPS_OVER));               // R01 R03 R04
            outputEnable_n        <= !(next_state == OTPPS_RDSET ||
                                       next_state == OTPPS_CHECK ||
                                       next_state == OTPPS_VSET  ||
                                       next_state == OTPPS_VCHECK);               // R13
        end
    end

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            done     <= 1'b0;
            fail     <= 1'b0;
            failAddr <= 15'h0000;
        end else if (startJob) begin
            done <= 1'b0;
            fail <= 1'b0;
        end else if ((state == OTPPS_CHECK && !match && tooMany) ||
                     (state == OTPPS_VCHECK && !match)) begin
            done     <= 1'b1;
            fail     <= 1'b1;
            failAddr <= addr;
        end else if (state == OTPPS_VCHECK && lastAddr) begin
            done <= 1'b1;                                                         // R06
        end
    end

    assign busy = (state != OTPPS_IDLE) && (state != OTPPS_DONE);

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_no_read_while_pulse;
        @(posedge core_clk) disable iff (!nrst)
        !(chipEnable_n == 1'b0 && outputEnable_n == 1'b0);
    endproperty
    a_no_read_while_pulse: assert property (p_no_read_while_pulse) // R13
        else $error("chip enable and output enable low together");

    property p_data_driven_in_pulse;
        @(posedge core_clk) disable iff (!nrst)
        !chipEnable_n |-> !array_data_lines_oe_n;
    endproperty
    a_data_driven_in_pulse: assert property (p_data_driven_in_pulse) // R01
        else $error("data not driven during program pulse");

    property p_stable_in_pulse;
        @(posedge core_clk) disable iff (!nrst)
        (!chipEnable_n && !$past(chipEnable_n)) |->
            $stable(array_address_lines) && $stable(array_data_lines_out);
    endproperty
    a_stable_in_pulse: assert property (p_stable_in_pulse) // R04
        else $error("address or data moved during pulse");

    property p_pulse_cap;
        @(posedge core_clk) disable iff (!nrst)
        pulses <= 5'(`OTPPS_MAX_PULSES);
    endproperty
    a_pulse_cap: assert property (p_pulse_cap) // R02
        else $error("more than the allowed pulses");

    property p_no_over_mode2;
        @(posedge core_clk) disable iff (!nrst)
        modeTwo |-> state != OTPPS_OVER;
    endproperty
    a_no_over_mode2: assert property (p_no_over_mode2) // R05
        else $error("extra pulse in mode two");

    property p_addr_range;
        @(posedge core_clk) disable iff (!nrst)
        (imgKind == OTPPS_IMG_HALF && busy && state != OTPPS_FETCH) |->
            addr >= HALF_ADDR;
    endproperty
    a_addr_range: assert property (p_addr_range) // R09
        else $error("half image address below start");

    property p_last_to_verify;
        @(posedge core_clk) disable iff (!nrst)
        (state == OTPPS_NEXT && lastAddr) |=> state == OTPPS_VFETCH;
    endproperty
    a_last_to_verify: assert property (p_last_to_verify) // R06
        else $error("verify pass not entered after last address");

    property p_fill_no_fetch;
        @(posedge core_clk) disable iff (!nrst)
        (fetchNow && fillOnly) |=> wdata == `OTPPS_FILL_BYTE && !$past(imgRdReq);
    endproperty
    a_fill_no_fetch: assert property (p_fill_no_fetch) // R10
        else $error("fill byte not used in low half");

    c_mode1_over: cover property (@(posedge core_clk) state == OTPPS_OVER);
    c_retry: cover property (@(posedge core_clk) state == OTPPS_CHECK && !match && !tooMany);
    c_done_ok: cover property (@(posedge core_clk) done && !fail);
endmodule

// ### design/otpps_timer.sv
// Purpose: down-counting cycle timer with load and done
// Assumes: load has priority over counting
// Notes: done is high while the count is zero
`include "otpps_defines.svh"
module otpps_timer
    import otpps_pkg::*;
#(
    parameter int W = 24
) (
    input  wire logic         core_clk,
    input  wire logic         nrst,
    input  wire logic         load,
    input  wire logic [W-1:0] loadVal,
    output logic              done
);
    logic [W-1:0] count;
    logic [W-1:0] next_count;

    assign next_count = load ? loadVal : (count != '0 ? count - W'(1) : count);
    assign done       = (count == '0);

    always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end
endmodule

// ### inc/otpps_defines.svh
// Purpose: constants for the one-time-programmable array programming sequencer
// Assumes: 100 MHz core_clk, period 10 ns
// Notes: pulse timing counts derive from times in microseconds; setup and settle counts are given in cycles
//
// Notes on behaviour
// [R01] In mode I each attempt holds address and data stable and gives one 1 ms low pulse on chip enable.
// [R02] In mode I every pulse is followed by a read-back, and a mismatch gives another 1 ms pulse, up to 25 pulses.
// [R03] In mode I a verified location gets one extra pulse of three times the pulse count times 1 ms.
// [R04] In mode II each attempt holds address and data stable and gives one 0.1 ms chip-enable pulse.
// [R05] In mode II every pulse is verified and repeated on mismatch up to 25 times, with no extra pulse.
// [R06] After all addresses are programmed a second pass reads and compares every address.
// [R07] The device array spans addresses 0000 to 7FFF and a full image ends at 7FFF.
// [R08] A 32KB image taken from 8000-FFFF is placed at 0000-7FFF.
// [R09] A 16KB image taken from C000-FFFF is placed at 4000-7FFF and writing starts at 4000.
// [R10] A 16KB image may instead fill 0000-3FFF with FF.
// [R11] The sequencer never performs an identification read and never drives raised levels on addresses.
// [R12] The link uses 15 address lines, 8 data lines, and active-low chip and output enables.
// [R13] Read-back drives output enable low with chip enable high and samples data after settling.
`ifndef OTPPS_DEFINES_SVH
`define OTPPS_DEFINES_SVH
`define OTPPS_CLK_MHZ        100
`define OTPPS_PULSE1_US      1000
`define OTPPS_PULSE2_US      100
`define OTPPS_SETUP_CYC      4
`define OTPPS_SETTLE_CYC     4
`define OTPPS_MAX_PULSES     25
`define OTPPS_OVER_FACTOR    3
`define OTPPS_ADDR_FIRST     15'h0000
`define OTPPS_ADDR_HALF      15'h4000
`define OTPPS_ADDR_LAST      15'h7FFF
`define OTPPS_SRC_BASE32     16'h8000
`define OTPPS_SRC_BASE16     16'hC000
`define OTPPS_FILL_BYTE      8'hFF
`endif

// ### inc/otpps_pkg.sv
// Purpose: types for the programming sequencer
// Assumes: nothing
// Notes: states are binary coded
package otpps_pkg;
    typedef enum logic [3:0] {
        OTPPS_IDLE    = 4'h0,
        OTPPS_FETCH   = 4'h1,
        OTPPS_SETUP   = 4'h2,
        OTPPS_PULSE   = 4'h3,
        OTPPS_RDSET   = 4'h4,
        OTPPS_CHECK   = 4'h5,
        OTPPS_OVER    = 4'h6,
        OTPPS_NEXT    = 4'h7,
        OTPPS_VFETCH  = 4'h8,
        OTPPS_VSET    = 4'h9,
        OTPPS_VCHECK  = 4'hA,
        OTPPS_DONE    = 4'hB
    } otpps_state_t;
    typedef enum logic [1:0] {
        OTPPS_IMG_FULL = 2'h0,
        OTPPS_IMG_HALF = 2'h1,
        OTPPS_IMG_FILL = 2'h2
    } otpps_img_t;
endpackage

// ### verification/otpps_prom_model.sv
// Purpose: behavioural one-time array seen on its programming pins
// Assumes: host strobes change just after core_clk rising edges
// Notes: a cell takes 1 to 4 pulses by address; one address may be stuck
module otpps_prom_model (
    input  wire logic        core_clk,
    input  wire logic        newPart,
    input  wire logic        stuckEn,
    input  wire logic [14:0] stuckAddr,
    input  wire logic [14:0] array_address_lines,
    input  wire logic [7:0]  hostData,
    input  wire logic        hostOe_n,
    input  wire logic        chipEnable_n,
    input  wire logic        outputEnable_n,
    output logic [7:0]       busLevel,
    output logic             fault
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  mem [0:32767];
    int          pcnt [0:32767];
    int          firstW [0:32767];
    int          lastW [0:32767];
    int          rdCnt [0:32767];
    int          width = 0;
    logic [7:0]  lastBus = 8'h00;
    logic        ceDly = 1'b1;
    logic        oeDly = 1'b1;
    logic [14:0] pa;
    logic [7:0]  pd;
    logic        devDrive;
    // ----------------------------------------
    // pins
    // ----------------------------------------
    assign devDrive = !outputEnable_n && chipEnable_n;
    assign busLevel = !hostOe_n ? hostData : devDrive ? mem[array_address_lines] : ~lastBus;
    // ----------------------------------------
    // program and read
    // ----------------------------------------
    always @(posedge core_clk) begin
        lastBus <= busLevel;
        ceDly <= chipEnable_n;
        oeDly <= outputEnable_n;
        if (newPart) begin
            fault <= 1'b0;
            for (int i = 0; i < 32768; i++) begin
                mem[i] = 8'hFF;
                pcnt[i] = 0;
                firstW[i] = 0;
                lastW[i] = 0;
                rdCnt[i] = 0;
            end
        end
        if ((!hostOe_n && devDrive) || (!chipEnable_n && !outputEnable_n)) begin
            fault <= 1'b1;
        end
        if (!chipEnable_n) begin
            if (ceDly) begin
                pa = array_address_lines;
                pd = hostData;
            end
            if (pa !== array_address_lines || pd !== hostData || hostOe_n) begin
                fault <= 1'b1;
            end
            width = width + 1;
        end else if (!ceDly) begin
            pcnt[pa] = pcnt[pa] + 1;
            if (pcnt[pa] == 1) begin
                firstW[pa] = width;
            end
            lastW[pa] = width;
            if (pcnt[pa] > int'(pa[1:0]) && !(stuckEn && pa == stuckAddr)) begin
                mem[pa] = mem[pa] & pd;
            end
            width = 0;
        end
        if (oeDly && !outputEnable_n) begin
            rdCnt[array_address_lines] = rdCnt[array_address_lines] + 1;
        end
    end
endmodule

// ### verification/otpps_sequencer_tb.sv
// Purpose: self-checking bench for the programming sequencer
// Assumes: short pulse parameters stand in for 1 ms and 0.1 ms
// Notes: image byte is a fixed function of its source address; a short array span keeps runs brief
module otpps_sequencer_tb;
    import otpps_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int P1    = 2;
    localparam int P2    = 1;
    localparam int LIMIT = 50000;
    localparam logic [14:0] HALF = 15'h0008;
    localparam logic [14:0] LAST = 15'h000F;
    logic        core_clk, nrst, start, modeTwo, newPart, stuckEn;
    otpps_img_t  imgKind;
    logic [14:0] stuckAddr, array_address_lines, failAddr;
    logic [15:0] imgRdAddr;
    logic [7:0]  imgRdData, dataOut, busLevel;
    logic        imgRdReq, dataOe_n, chipEnable_n, outputEnable_n;
    logic        busy, done, fail, fault;
    int          n_mismatch = 0;
    int          comparisons = 0;
    int          cycles = 0;
    // ----------------------------------------
    // design and far side
    // ----------------------------------------
    function automatic logic [7:0] img(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5A;
    endfunction
    assign imgRdData = img(imgRdAddr);
    otpps_sequencer #(.PULSE1_CYC(P1), .PULSE2_CYC(P2),
                      .HALF_ADDR(HALF), .LAST_ADDR(LAST)) dut (
        .core_clk(core_clk), .nrst(nrst), .start(start), .modeTwo(modeTwo),
        .imgKind(imgKind), .imgRdReq(imgRdReq), .imgRdAddr(imgRdAddr),
        .imgRdData(imgRdData), .array_address_lines(array_address_lines),
        .array_data_lines_out(dataOut), .array_data_lines_oe_n(dataOe_n),
        .array_data_lines_in(busLevel), .chipEnable_n(chipEnable_n),
        .outputEnable_n(outputEnable_n), .busy(busy), .done(done), .fail(fail),
        .failAddr(failAddr));
    otpps_prom_model m (
        .core_clk(core_clk), .newPart(newPart), .stuckEn(stuckEn), .stuckAddr(stuckAddr),
        .array_address_lines(array_address_lines), .hostData(dataOut),
        .hostOe_n(dataOe_n), .chipEnable_n(chipEnable_n),
        .outputEnable_n(outputEnable_n), .busLevel(busLevel), .fault(fault));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    task automatic summarize();
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic run_job(input logic mode, input otpps_img_t kind, input logic sEn,
                           input logic [14:0] sAddr, input logic again);
        @(posedge core_clk);
        #1;
        newPart = 1'b1;
        modeTwo = mode;
        imgKind = kind;
        stuckEn = sEn;
        stuckAddr = sAddr;
        @(posedge core_clk);
        #1;
        newPart = 1'b0;
        start = 1'b1;
        @(posedge core_clk);
        #1;
        start = 1'b0;
        chk("busy after start", 1, busy);
        if (again) begin
            repeat (30) @(posedge core_clk);
            #1;
            start = 1'b1;
            @(posedge core_clk);
            #1;
            start = 1'b0;
        end
        while (busy !== 1'b0) begin
            @(posedge core_clk);
            #1;
        end
        chk("done", 1, done);
        chk("pin fault", 0, fault);
    endtask
    task automatic check_loc(input logic [14:0] a, input logic [7:0] d, input logic mode,
                             input logic stuck, input int vfy);
        int k;
        int p;
        int lw;
        k = (d == 8'hFF) ? 1 : int'(a[1:0]) + 1;
        p = mode ? P2 : P1;
        if (stuck) k = 25;
        lw = (mode || stuck) ? p : 3 * k * P1;
        chk("pulses", (mode || stuck) ? k : k + 1, m.pcnt[a]);
        chk("pulse width", p, m.firstW[a]);
        chk("last pulse width", lw, m.lastW[a]);
        chk("cell", stuck ? 8'hFF : d, m.mem[a]);
        chk("reads", stuck ? 25 : k + vfy, m.rdCnt[a]);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic s_reset();
        chk("ce idle", 1, chipEnable_n);
        chk("oe idle", 1, outputEnable_n);
        chk("drive idle", 1, dataOe_n);
        chk("busy idle", 0, busy);
        chk("done idle", 0, done);
        chk("fail idle", 0, fail);
    endtask
    task automatic s_half_mode_one();
        run_job(1'b0, OTPPS_IMG_HALF, 1'b0, 15'h0000, 1'b0);
        chk("fail", 0, fail);
        chk("below start", 0, m.pcnt[15'h0007]);
        for (int i = 0; i < 4; i++) begin
            check_loc(HALF + 15'(i), img(16'hC008 + 16'(i)), 1'b0, 1'b0, 1);
        end
        check_loc(LAST, img(16'hC00F), 1'b0, 1'b0, 1);
    endtask
    task automatic s_full_mode_two_stuck();
        run_job(1'b1, OTPPS_IMG_FULL, 1'b1, 15'h0006, 1'b1);
        chk("fail", 1, fail);
        chk("fail address", 15'h0006, failAddr);
        for (int i = 0; i < 6; i++) begin
            check_loc(15'(i), img(16'h8000 + 16'(i)), 1'b1, 1'b0, 0);
        end
        check_loc(15'h0006, img(16'h8006), 1'b1, 1'b1, 0);
        chk("stopped", 0, m.pcnt[15'h0007]);
    endtask
    task automatic s_fill_mode_one_stuck();
        run_job(1'b0, OTPPS_IMG_FILL, 1'b1, 15'h000A, 1'b0);
        chk("fail", 1, fail);
        chk("fail address", 15'h000A, failAddr);
        check_loc(15'h0000, 8'hFF, 1'b0, 1'b0, 0);
        check_loc(15'h0007, 8'hFF, 1'b0, 1'b0, 0);
        check_loc(15'h0008, img(16'hC008), 1'b0, 1'b0, 0);
        check_loc(15'h0009, img(16'hC009), 1'b0, 1'b0, 0);
        check_loc(15'h000A, img(16'hC00A), 1'b0, 1'b1, 0);
    endtask
    // ----------------------------------------
    // clock, watchdog, sequence
    // ----------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_mismatch++;
            $display("ERROR timeout expected done seen busy");
            summarize();
        end
    end
    initial begin
        nrst = 1'b0;
        start = 1'b0;
        modeTwo = 1'b0;
        imgKind = OTPPS_IMG_FULL;
        newPart = 1'b1;
        stuckEn = 1'b0;
        stuckAddr = 15'h0000;
        repeat (16) @(posedge core_clk);
        #1;
        s_reset();
        nrst = 1'b1;
        s_half_mode_one();
        s_full_mode_two_stuck();
        s_fill_mode_one_stuck();
        summarize();
    end
endmodule
